// ### dv/rqw_chk.sv
// Concurrent checks on the request stream between requester and framer
`timescale 1ns/1ps
module rqw_chk
  import rqw_pkg::*;
(
  input wire logic            core_clk,
  input wire logic            rstn,
  input wire logic [DW-1:0]   request_data,
  input wire logic [NDW-1:0]  request_dword_keep,
  input wire logic            request_valid,
  input wire logic            request_ready,
  input wire logic            request_last_beat,
  input wire logic [SB_W-1:0] request_sideband
);
  logic in_pkt_q;
  wire  take     = request_valid && request_ready;
  wire  first    = request_valid && !in_pkt_q;
  wire  in_pkt_d = take ? !request_last_beat : in_pkt_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      in_pkt_q <= 1'b0;
    end else begin
      in_pkt_q <= in_pkt_d;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_stalled; request_valid && !request_ready; endsequence
  sequence s_mid_take; take && !request_last_beat; endsequence
  sequence s_end_take; take && request_last_beat; endsequence
  a_hold_on_stall:
    assert property (s_stalled |=> request_valid && $stable(request_data)
      && $stable(request_dword_keep) && $stable(request_last_beat)
      && $stable(request_sideband)) else $error("beat changed while stalled");
  a_valid_held:
    assert property (s_mid_take |=> request_valid) else $error("valid dropped in packet");
  a_gap_after_end:
    assert property (s_end_take |=> !request_valid) else $error("no idle after packet");
  a_keep_contig:
    assert property (request_valid |-> request_dword_keep[0]
      && ((request_dword_keep & (request_dword_keep + 8'h01)) == 8'h00))
      else $error("keep not contiguous");
  a_keep_full_mid:
    assert property (request_valid && !request_last_beat |-> request_dword_keep == 8'hff)
      else $error("keep short before last beat");
  a_desc_lanes:
    assert property (first |-> (request_dword_keep & DESC_LANES) == DESC_LANES)
      else $error("descriptor lanes not kept");
  a_single_lbe:
    assert property (first && request_last_beat && request_dword_keep == 8'h1f
      |-> request_sideband[SB_LBE_LSB +: 4] == 4'h0) else $error("single dword lbe set");
  a_no_discont:
    assert property (request_valid |-> !request_sideband[SB_DISC_BIT])
      else $error("discontinue raised");
  a_offset_beat:
    assert property (first && request_sideband[SB_OFF_LSB +: 3] != 3'h0
      |-> request_dword_keep == 8'hff && !request_last_beat)
      else $error("offset payload in first beat");
endmodule

// ### dv/rqw_framer_tb.sv
// Bench joining requester and framer across the request stream
`timescale 1ns/1ps
module rqw_framer_tb
  import rqw_pkg::*;
;
  localparam logic [3:0] MTY [8] = '{RT_LTR, RT_OBFF, RT_OBFF, RT_OBFF, RT_OBFF,
    RT_VDM, RT_ATS, RT_MSG};
  localparam logic [3:0] MOC [8] = '{4'h0, 4'hf, 4'h1, 4'h0, 4'h5, 4'h0, 4'h0, 4'h0};
  logic            core_clk, rstn, reg_write, reg_read, link_hold, stall_en;
  logic            cfg_ecrc_enable, cfg_addr_aligned;
  logic [7:0]      reg_addr, tlp_msg_code;
  logic [31:0]     reg_wdata, reg_rdata, tlp_hdr_dw2, tlp_hdr_dw3, rd_q;
  logic [2:0]      cfg_attr_enable, tlp_routing, tlp_attr, tlp_addr_offset;
  logic            tlp_hdr_valid, tlp_digest, tlp_data_valid, tlp_end, tlp_nullify;
  logic [3:0]      tlp_req_type, tlp_first_dword_byte_enable, tlp_last_dword_byte_enable;
  logic [DW-1:0]   tlp_data;
  logic [NDW-1:0]  tlp_keep;
  logic [31:0]     got_q[$];
  int              n_mismatch, total_checks, n_pkt;
  rqw_if rq_bus();
  rqw_requester u_rqw_requester (.core_clk, .rstn, .rq(rq_bus), .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata);
  rqw_framer u_rqw_framer (.core_clk, .rstn, .rq(rq_bus), .link_hold, .cfg_attr_enable,
    .cfg_ecrc_enable, .cfg_addr_aligned, .tlp_hdr_valid, .tlp_req_type, .tlp_msg_code,
    .tlp_routing, .tlp_attr, .tlp_digest, .tlp_hdr_dw2, .tlp_hdr_dw3, .tlp_first_dword_byte_enable,
    .tlp_last_dword_byte_enable, .tlp_addr_offset, .tlp_data, .tlp_keep, .tlp_data_valid, .tlp_end,
    .tlp_nullify);
  rqw_chk u_rqw_chk (.core_clk, .rstn,
    .request_data(rq_bus.request_data), .request_dword_keep(rq_bus.request_dword_keep),
    .request_valid(rq_bus.request_valid), .request_ready(rq_bus.request_ready),
    .request_last_beat(rq_bus.request_last_beat),
    .request_sideband(rq_bus.request_sideband));
  // ---------------------------------------------------------------
  // Clock, stall pattern and payload monitor
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Stall every other cycle
  always @(posedge core_clk) begin
    link_hold <= stall_en & ~link_hold;
  end
  // Off-edge sampling of settled outputs
  always @(negedge core_clk) begin
    if (tlp_data_valid === 1'b1) begin
      for (int i = 0; i < NDW; i++) begin
        if (tlp_keep[i] === 1'b1) got_q.push_back(tlp_data[32*i +: 32]);
      end
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_read  <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  function automatic logic [127:0] mk(input logic [3:0] ty, input logic [7:0] code,
    input logic [2:0] rt, input logic [3:0] top, input logic [63:0] lo);
    mk = '0;
    mk[127:124]          = top;
    mk[D_ROUTE_LSB +: 3] = rt;
    mk[D_CODE_LSB +: 8]  = code;
    mk[D_TYPE_LSB +: 4]  = ty;
    mk[63:0]             = lo;
  endfunction
  // One request: load, fire, judge payload
  task automatic send(input logic [127:0] desc, input logic [10:0] len,
    input logic [31:0] be, input logic nul);
    int n;
    got_q.delete();
    for (int i = 0; i < 4; i++) wr(REG_DESC0 + 8'(4 * i), desc[32*i +: 32]);
    wr(REG_LEN, {21'h0, len});
    wr(REG_BE, be);
    wr(REG_BASE, 32'h5a00_0000 + 32'(len));
    wr(REG_CMD, 32'h1);
    @(posedge core_clk);
    reg_write <= 1'b0;
    n = 0;
    while (tlp_end !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 400) begin
      n_mismatch++;
      end_of_test();
    end
    chk({31'h0, tlp_nullify}, {31'h0, nul});
    @(negedge core_clk);
    n_pkt++;
    chk(got_q.size(), (len == 0) ? 32'h1 : 32'(len));
    for (int i = 0; i < got_q.size() && len != 0; i++) begin
      chk(got_q[i], 32'h5a00_0000 + 32'(len) + 32'(i));
    end
    repeat (2) @(posedge core_clk);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_memwr();
    cfg_attr_enable <= 3'b010;
    send(mk(RT_MEMWR, 8'h0, 3'h0, 4'hf, 64'h0), 11'd6, 32'h0000_00ff, 1'b0);
    chk({31'h0, tlp_digest}, 32'h1);
    chk({29'h0, tlp_attr}, 32'h2);
    send(mk(RT_MEMWR, 8'h0, 3'h0, 4'h0, 64'h0), 11'd1, 32'h0000_00f3, 1'b0);
    chk({28'h0, tlp_first_dword_byte_enable}, 32'h3);
    chk({28'h0, tlp_last_dword_byte_enable}, 32'h0);
    chk({31'h0, tlp_digest}, 32'h0);
    send(mk(RT_MEMWR, 8'h0, 3'h0, 4'h0, 64'h0), 11'd0, 32'h0000_00ff, 1'b0);
    chk({24'h0, tlp_last_dword_byte_enable, tlp_first_dword_byte_enable}, 32'h0);
  endtask
  task automatic t_stall_aligned();
    stall_en = 1'b1;
    send(mk(RT_MEMWR, 8'h0, 3'h0, 4'h0, 64'h0), 11'd20, 32'h0000_00ff, 1'b0);
    stall_en = 1'b0;
    cfg_addr_aligned <= 1'b1;
    cfg_ecrc_enable  <= 1'b1;
    send(mk(RT_MEMWR, 8'h0, 3'h0, 4'h0, 64'h0), 11'd10, 32'h0001_03ff, 1'b0);
    chk({29'h0, tlp_addr_offset}, 32'h3);
    chk({31'h0, tlp_digest}, 32'h1);
    cfg_addr_aligned <= 1'b0;
    cfg_ecrc_enable  <= 1'b0;
  endtask
  task automatic t_msgs();
    logic [63:0] lo;
    logic [2:0]  rt;
    logic [31:0] e2, e3;
    for (int i = 0; i < 8; i++) begin
      lo = 64'h1357_9bd0_2468_ace0 | {28'h0, MOC[i], 32'h0};
      rt = (MTY[i] == RT_VDM) ? ROUTE_BY_ID : 3'(i);
      e2 = 32'h0;
      e3 = 32'h0;
      case (MTY[i])
        RT_LTR:  e3 = {lo[15:0], lo[31:16]};
        RT_OBFF: e3 = {28'h0, MOC[i]};
        RT_VDM: begin
          e2 = {lo[15:0], 16'h0};
          e3 = lo[63:32];
        end
        RT_ATS: begin
          e2 = lo[31:0];
          e3 = lo[63:32];
        end
      endcase
      send(mk(MTY[i], 8'h10 + 8'(i), rt, 4'h0, lo), 11'd1, 32'h0000_000f,
           MOC[i] == 4'h5);
      chk({28'h0, tlp_req_type}, {28'h0, MTY[i]});
      chk({24'h0, tlp_msg_code}, 32'h10 + 32'(i));
      chk({29'h0, tlp_routing}, {29'h0, rt});
      chk(tlp_hdr_dw2, e2);
      chk(tlp_hdr_dw3, e3);
    end
  endtask
  task automatic t_status();
    rd(REG_STAT);
    chk(rd_q, {16'(n_pkt), 16'h0});
    rd(REG_CMD);
    chk(rd_q, 32'h0);
    rd(8'h40);
    chk(rd_q, 32'h0);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    link_hold = 1'b0;
    stall_en = 1'b0;
    cfg_attr_enable = 3'b111;
    cfg_ecrc_enable = 1'b0;
    cfg_addr_aligned = 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    t_memwr();
    t_stall_aligned();
    t_msgs();
    t_status();
    end_of_test();
  end
endmodule

// ### logic/rqw_framer.sv
// Device end: turns accepted request beats into packet header and payload
`timescale 1ns/1ps
module rqw_framer
  import rqw_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           rstn,
  rqw_if.device               rq,
  input  wire logic           link_hold,
  input  wire logic [2:0]     cfg_attr_enable,
  input  wire logic           cfg_ecrc_enable,
  input  wire logic           cfg_addr_aligned,
  output logic                tlp_hdr_valid,
  output logic      [3:0]     tlp_req_type,
  output logic      [7:0]     tlp_msg_code,
  output logic      [2:0]     tlp_routing,
  output logic      [2:0]     tlp_attr,
  output logic                tlp_digest,
  output logic      [31:0]    tlp_hdr_dw2,
  output logic      [31:0]    tlp_hdr_dw3,
  output logic      [3:0]     tlp_first_dword_byte_enable,
  output logic      [3:0]     tlp_last_dword_byte_enable,
  output logic      [2:0]     tlp_addr_offset,
  output logic      [DW-1:0]  tlp_data,
  output logic      [NDW-1:0] tlp_keep,
  output logic                tlp_data_valid,
  output logic                tlp_end,
  output logic                tlp_nullify
);
  rqw_fr_state_type state_q;
  logic ready_q, err_q, bad_q, sec_q;
  logic hv_q, dig_q, dv_q, end_q, null_q;
  logic [3:0] type_q, fbe_q, lbe_q;
  logic [7:0] code_q;
  logic [2:0] route_q, attr_q, off_q;
  logic [31:0] dw2_q, dw3_q;
  logic [DW-1:0] data_q;
  logic [NDW-1:0] keep_q;

  // ---------------------------------------------------------------
  // Descriptor decode
  // ---------------------------------------------------------------
  wire         beat  = rq.request_valid && ready_q;
  wire         first = beat && (state_q == FR_IDLE);
  wire [127:0] desc  = rq.request_data[127:0];
  wire [3:0]   rtype = desc[D_TYPE_LSB +: 4];
  wire [2:0]   route = desc[D_ROUTE_LSB +: 3];
  wire [3:0]   obff  = desc[D_OBFF_LSB +: 4];
  wire is_ltr  = rtype == RT_LTR;
  wire is_obff = rtype == RT_OBFF;
  wire is_vdm  = rtype == RT_VDM;
  wire is_ats  = rtype == RT_ATS;
  // Reserved flush codes must not reach the link
  wire obff_bad = is_obff && !(obff == OBFF_CPU_ACTIVE || obff == OBFF_MEM_PATH
                              || obff == OBFF_IDLE);
  wire [31:0] dw2_d =
    is_ats ? desc[31:0] :
    (is_vdm && route == ROUTE_BY_ID) ? {desc[D_DEST_LSB +: 16], 16'h0000} :
    32'h0000_0000;
  wire [31:0] dw3_d =
    (is_ats || is_vdm) ? desc[D_HI_LSB +: 32] :
    is_ltr  ? {desc[D_SNOOP_LSB +: 16], desc[D_NOSNOOP_LSB +: 16]} :
    is_obff ? {28'h0000000, obff} : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Error tracking
  // ---------------------------------------------------------------
  wire gap      = (state_q == FR_BODY) && !rq.request_valid;
  wire disc     = beat && rq.request_sideband[SB_DISC_BIT];
  wire end_beat = beat && rq.request_last_beat;
  wire bad_now  = first ? obff_bad : bad_q;
  wire null_d   = err_q || gap || disc || bad_now;
  // First beat carries descriptor lanes; only Dword mode has payload there
  wire [NDW-1:0] lead_mask = (cfg_addr_aligned && sec_q) ? 8'hff << off_q : 8'hff;
  wire [NDW-1:0] pay_keep = !first ? rq.request_dword_keep & lead_mask :
                            cfg_addr_aligned ? '0 : rq.request_dword_keep & ~DESC_LANES;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= FR_IDLE;
    end else begin
      unique case (state_q)
        FR_IDLE: if (first && !rq.request_last_beat) state_q <= FR_BODY;
        FR_BODY: if (end_beat) state_q <= FR_IDLE;
      endcase
    end
  end

  // Error is sticky to packet end; a late event still lands in null_d
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      err_q <= 1'b0;
    end else if (end_beat) begin
      err_q <= 1'b0;
    end else if (gap || disc) begin
      err_q <= 1'b1;
    end
  end

  // Ready is registered so the link can stall the user one cycle on
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= !link_hold;
    end
  end

  // ---------------------------------------------------------------
  // Header capture
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      type_q  <= 4'h0;
      code_q  <= 8'h00;
      route_q <= 3'h0;
      attr_q  <= 3'h0;
      dig_q   <= 1'b0;
      dw2_q   <= 32'h0000_0000;
      dw3_q   <= 32'h0000_0000;
      fbe_q   <= 4'h0;
      lbe_q   <= 4'h0;
      off_q   <= 3'h0;
      bad_q   <= 1'b0;
    end else if (first) begin
      type_q  <= rtype;
      code_q  <= desc[D_CODE_LSB +: 8];
      route_q <= route;
      attr_q  <= desc[D_ATTR_LSB +: 3] & cfg_attr_enable;
      dig_q   <= desc[D_ECRC_BIT] | cfg_ecrc_enable;
      dw2_q   <= dw2_d;
      dw3_q   <= dw3_d;
      fbe_q   <= rq.request_sideband[SB_FBE_LSB +: 4];
      lbe_q   <= rq.request_sideband[SB_LBE_LSB +: 4];
      off_q   <= rq.request_sideband[SB_OFF_LSB +: 3];
      bad_q   <= obff_bad;
    end
  end

  // ---------------------------------------------------------------
  // Payload and packet end
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hv_q   <= 1'b0;
      dv_q   <= 1'b0;
      keep_q <= '0;
      end_q  <= 1'b0;
      null_q <= 1'b0;
      sec_q  <= 1'b0;
    end else begin
      hv_q   <= first;
      dv_q   <= beat && (|pay_keep);
      keep_q <= beat ? pay_keep : '0;
      end_q  <= end_beat;
      null_q <= end_beat && null_d;
      sec_q  <= beat ? first : sec_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      data_q <= '0;
    end else if (beat) begin
      data_q <= rq.request_data;
    end
  end

  assign rq.request_ready  = ready_q;
  assign tlp_hdr_valid     = hv_q;
  assign tlp_req_type      = type_q;
  assign tlp_msg_code      = code_q;
  assign tlp_routing       = route_q;
  assign tlp_attr          = attr_q;
  assign tlp_digest        = dig_q;
  assign tlp_hdr_dw2       = dw2_q;
  assign tlp_hdr_dw3       = dw3_q;
  assign tlp_first_dword_byte_enable      = fbe_q;
  assign tlp_last_dword_byte_enable       = lbe_q;
  assign tlp_addr_offset   = off_q;
  assign tlp_data          = data_q;
  assign tlp_keep          = keep_q;
  assign tlp_data_valid    = dv_q;
  assign tlp_end           = end_q;
  assign tlp_nullify       = null_q;
endmodule

// ### logic/rqw_if.sv
// Request stream between requester logic and the framer
`timescale 1ns/1ps
interface rqw_if
  import rqw_pkg::*;
  ;
  logic [DW-1:0]   request_data;
  logic [NDW-1:0]  request_dword_keep;
  logic            request_valid;
  logic            request_ready;
  logic            request_last_beat;
  logic [SB_W-1:0] request_sideband;

  modport device (
    input  request_data,
    input  request_dword_keep,
    input  request_valid,
    input  request_last_beat,
    input  request_sideband,
    output request_ready
  );
  modport host (
    output request_data,
    output request_dword_keep,
    output request_valid,
    output request_last_beat,
    output request_sideband,
    input  request_ready
  );
endinterface

// ### logic/rqw_lane.sv
// One Dword lane of an outgoing request beat
`timescale 1ns/1ps
module rqw_lane
  import rqw_pkg::*;
#(
  parameter int LANE = 0
) (
  input  wire logic [BEAT_W-1:0] beat,
  input  wire logic [127:0]      desc,
  input  wire logic [SLOT_W-1:0] pay_start,
  input  wire logic [LEN_W-1:0]  pay_len,
  input  wire logic [31:0]       base,
  output logic      [31:0]       dword,
  output logic                   keep
);
  // Slot counts Dwords from the descriptor start over the whole packet
  wire [SLOT_W-1:0] slot    = {beat, 3'(LANE)};
  wire [SLOT_W-1:0] pidx    = slot - pay_start;
  wire              is_desc = slot < SLOT_W'(DESC_DWS);
  wire              is_pay  = (slot >= pay_start) && (pidx < pay_len);

  assign keep  = is_desc | is_pay | (slot < pay_start);
  assign dword = is_desc ? desc[32*slot[1:0] +: 32] :
                 is_pay  ? base + 32'(pidx) : 32'h0000_0000;
endmodule

// ### logic/rqw_pkg.sv
// Constants and types shared by both ends of the request framer link
// ---------------------------------------------------------------
// Contract
// - Descriptor bit 127 forces digest on packet
// - Mask attributes not enabled by function
// - LTR: snoop and no-snoop latency copied
// - Flush code: 1111, 0001, 0000 only
// - Copy message code into header
// - Copy routing bits into header
// - Routed-by-id vendor message carries destination id
// - Vendor message: bits 63:32 to Dword 3
// - Translation message: bits 63:0 to Dwords 2-3
// - Dword mode: payload follows descriptor directly
// - Valid held whole packet; drop nullifies packet
// - Last-beat marker on final beat
// - Hold all signals while ready low
// - Keep bits contiguous descriptor through payload
// - Keep cleared only in short final beat
// - Byte enables given on first beat
// - Payload within max size, no 4K crossing
// - Non-contiguous enables only for short writes
// - Zero-length write sends dummy Dword, enables zero
// - Single Dword: last enable zero
// - Address mode: payload next beat, lane reported
// ---------------------------------------------------------------
package rqw_pkg;
  // Stream geometry
  localparam int DW       = 256;
  localparam int NDW      = 8;
  localparam int SB_W     = 12;
  localparam int BEAT_W   = 8;
  localparam int SLOT_W   = BEAT_W + 3;
  localparam int LEN_W    = SLOT_W;
  localparam int DESC_DWS = 4;
  localparam logic [NDW-1:0] DESC_LANES = 8'h0f;
  // Sideband field positions
  localparam int SB_FBE_LSB  = 0;
  localparam int SB_LBE_LSB  = 4;
  localparam int SB_OFF_LSB  = 8;
  localparam int SB_DISC_BIT = 11;
  // Descriptor field positions
  localparam int D_ECRC_BIT    = 127;
  localparam int D_ATTR_LSB    = 124;
  localparam int D_ROUTE_LSB   = 112;
  localparam int D_CODE_LSB    = 104;
  localparam int D_TYPE_LSB    = 75;
  localparam int D_SNOOP_LSB   = 0;
  localparam int D_NOSNOOP_LSB = 16;
  localparam int D_OBFF_LSB    = 32;
  localparam int D_DEST_LSB    = 0;
  localparam int D_HI_LSB      = 32;
  // Request kinds
  localparam logic [3:0] RT_MEMWR = 4'h1;
  localparam logic [3:0] RT_MSG   = 4'h8;
  localparam logic [3:0] RT_LTR   = 4'h9;
  localparam logic [3:0] RT_OBFF  = 4'ha;
  localparam logic [3:0] RT_VDM   = 4'hb;
  localparam logic [3:0] RT_ATS   = 4'hc;
  localparam logic [3:0] OBFF_CPU_ACTIVE = 4'hf;
  localparam logic [3:0] OBFF_MEM_PATH   = 4'h1;
  localparam logic [3:0] OBFF_IDLE       = 4'h0;
  localparam logic [2:0] ROUTE_BY_ID     = 3'h2;
  // Requester register map
  localparam logic [7:0] REG_DESC0 = 8'h00;
  localparam logic [7:0] REG_LEN   = 8'h10;
  localparam logic [7:0] REG_BE    = 8'h14;
  localparam logic [7:0] REG_BASE  = 8'h18;
  localparam logic [7:0] REG_CMD   = 8'h1c;
  localparam logic [7:0] REG_STAT  = 8'h20;
  localparam int BE_FBE_LSB    = 0;
  localparam int BE_LBE_LSB    = 4;
  localparam int BE_OFF_LSB    = 8;
  localparam int BE_AA_BIT     = 16;
  localparam int CMD_GO_BIT    = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CNT_LSB  = 16;
  localparam logic [LEN_W-1:0] LEN_RST  = 11'h000;
  localparam logic [31:0]      BASE_RST = 32'h0000_0000;

  typedef enum logic [1:0] {FR_IDLE = 2'b01, FR_BODY = 2'b10} rqw_fr_state_type;
  typedef enum logic [1:0] {HS_IDLE = 2'b01, HS_SEND = 2'b10} rqw_hs_state_type;
endpackage

// ### logic/rqw_requester.sv
// User-side requester: builds request packets from its registers
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module rqw_requester
  import rqw_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  rqw_if.host              rq,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  rqw_hs_state_type  state_q;
  logic [31:0]       desc_q [0:DESC_DWS-1];
  logic [LEN_W-1:0]  len_q;
  logic [3:0]        fbe_q;
  logic [3:0]        lbe_q;
  logic [2:0]        off_q;
  logic              aa_q;
  logic [31:0]       base_q;
  logic [BEAT_W-1:0] beat_q;
  logic [15:0]       cnt_q;
  logic [31:0]       rdata_q;
  logic              valid_q;
  logic [DW-1:0]     data_q;
  logic [NDW-1:0]    keep_q;
  logic              last_q;
  logic [SB_W-1:0]   sb_q;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire idle    = (state_q == HS_IDLE);
  // Setup writes are ignored mid-packet so the held beat cannot change
  wire cfg_wr  = reg_write && idle;
  wire wr_desc = cfg_wr && (reg_addr[7:4] == REG_DESC0[7:4]);
  wire wr_len  = cfg_wr && (reg_addr == REG_LEN);
  wire wr_be   = cfg_wr && (reg_addr == REG_BE);
  wire wr_base = cfg_wr && (reg_addr == REG_BASE);
  wire go      = cfg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_GO_BIT];

  // ---------------------------------------------------------------
  // Beat sequencing
  // ---------------------------------------------------------------
  wire accept   = valid_q && rq.request_ready;
  wire done     = accept && last_q;
  wire more     = accept && !last_q;
  // Apart from the first beat on go, a new beat is formed only after a handshake, so a stalled beat stays put
  wire load     = go || more;
  wire [BEAT_W-1:0] nbeat = go ? '0 : beat_q + 1'b1;

  wire              zero_len = (len_q == LEN_RST);
  wire [LEN_W-1:0]  eff_len  = zero_len ? LEN_W'(1) : len_q;
  // Dword mode packs payload right after the descriptor; aligned mode
  // starts it in the next beat at the chosen lane
  wire [SLOT_W-1:0] pay_start = aa_q ? SLOT_W'(NDW) + SLOT_W'(off_q)
                                     : SLOT_W'(DESC_DWS);
  wire [SLOT_W:0]   total    = {1'b0, pay_start} + {1'b0, eff_len};
  wire [SLOT_W:0]   beat_end = {1'b0, nbeat, 3'b000} + (SLOT_W+1)'(NDW);
  wire              last_d   = beat_end >= total;

  wire [3:0] fbe_eff = zero_len ? 4'h0 : fbe_q;
  wire [3:0] lbe_eff = (eff_len == LEN_W'(1)) ? 4'h0 : lbe_q;
  wire [2:0] off_eff = aa_q ? off_q : 3'h0;
  wire [SB_W-1:0] sb_d = {1'b0, off_eff, lbe_eff, fbe_eff};

  wire [127:0] desc_flat = {desc_q[3], desc_q[2], desc_q[1], desc_q[0]};
  logic [NDW-1:0][31:0] lane_dw;
  logic [NDW-1:0]       lane_keep;

  genvar g;
  generate
    for (g = 0; g < NDW; g++) begin : g_lane
      rqw_lane #(
        .LANE (g)
      ) u_lane (
        .beat      (nbeat),
        .desc      (desc_flat),
        .pay_start (pay_start),
        .pay_len   (eff_len),
        .base      (base_q),
        .dword     (lane_dw[g]),
        .keep      (lane_keep[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  wire [31:0] be_word   = {15'h0000, aa_q, 5'h00, off_q, lbe_q, fbe_q};
  wire [31:0] stat_word = {cnt_q, 15'h0000, !idle};
  wire [31:0] rd_mux =
    (reg_addr[7:4] == REG_DESC0[7:4]) ? desc_q[reg_addr[3:2]] :
    (reg_addr == REG_LEN)             ? 32'(len_q) :
    (reg_addr == REG_BE)              ? be_word :
    (reg_addr == REG_BASE)            ? base_q :
    (reg_addr == REG_STAT)            ? stat_word : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Setup registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DESC_DWS; i++) begin
        desc_q[i] <= 32'h0000_0000;
      end
    end else if (wr_desc) begin
      desc_q[reg_addr[3:2]] <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      len_q <= LEN_RST;
    end else if (wr_len) begin
      len_q <= reg_wdata[LEN_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fbe_q <= 4'h0;
      lbe_q <= 4'h0;
      off_q <= 3'h0;
      aa_q  <= 1'b0;
    end else if (wr_be) begin
      fbe_q <= reg_wdata[BE_FBE_LSB +: 4];
      lbe_q <= reg_wdata[BE_LBE_LSB +: 4];
      off_q <= reg_wdata[BE_OFF_LSB +: 3];
      aa_q  <= reg_wdata[BE_AA_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      base_q <= BASE_RST;
    end else if (wr_base) begin
      base_q <= reg_wdata;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_read ? rd_mux : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Packet state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= HS_IDLE;
    end else begin
      unique case (state_q)
        HS_IDLE: if (go) state_q <= HS_SEND;
        HS_SEND: if (done) state_q <= HS_IDLE;
      endcase
    end
  end

  // Valid rises with the first beat and falls only after the last
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      valid_q <= 1'b0;
    end else if (go) begin
      valid_q <= 1'b1;
    end else if (done) begin
      valid_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 16'h0000;
    end else if (done) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      beat_q <= '0;
      data_q <= '0;
      keep_q <= '0;
      last_q <= 1'b0;
      sb_q   <= '0;
    end else if (load) begin
      beat_q <= nbeat;
      data_q <= lane_dw;
      keep_q <= lane_keep;
      last_q <= last_d;
      sb_q   <= sb_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rq.request_valid      = valid_q;
  assign rq.request_data       = data_q;
  assign rq.request_dword_keep = keep_q;
  assign rq.request_last_beat  = last_q;
  assign rq.request_sideband   = sb_q;
  assign reg_rdata             = rdata_q;
endmodule
